// ==== hdl/rpg_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef RPG_MAP_SVH
`define RPG_MAP_SVH
`define RPG_OFS_PIN_MASK      8'hac
`define RPG_OFS_TERM_DISCH    8'had
`define RPG_OFS_AUX_CTRL      8'hae
`define RPG_OFS_GOOD_LOW      8'hb0
`define RPG_TERM_DISCH_BIT    4
`define RPG_AUX_DISCH_HI      7
`define RPG_AUX_DISCH_LO      6
`define RPG_AUX_SDWN_BIT      5
`define RPG_AUX_VID_HI        4
`define RPG_AUX_VID_LO        1
`define RPG_AUX_EN_BIT        0
`define RPG_GOOD_RESET        8'h00
`define RPG_CLK_MHZ           100
`define RPG_SDWN_1MS_US       1000
`define RPG_SDWN_5MS_US       5000
`define RPG_SDWN_10MS_US      10000
`define RPG_SDWN_100MS_US     100000
`define RPG_US_TO_CYC(us)     ((us) * `RPG_CLK_MHZ)
`endif

// ==== hdl/rpg_pkg.sv ====
// types shared by the rail mask and auxiliary rail control block
package rpg_pkg;
   // register write/read port of the serial register interface
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rpg_req_t;
   // aux rail controls as driven to the analog side
   typedef struct packed {
      logic [1:0] disch_sel;
      logic       sdwn_ignore;
      logic [3:0] vcode;
      logic       enable;
   } rpg_aux_t;
   // shutdown timer states, gray along idle-run-hold
   typedef enum logic [1:0] {
      RPG_ST_IDLE = 2'b00,
      RPG_ST_RUN  = 2'b01,
      RPG_ST_HOLD = 2'b11
   } rpg_sdwn_st_t;
endpackage : rpg_pkg

// ==== hdl/rpg_rail_ctrl.sv ====
// register bank: pin masks, discharge, aux rail control, good status
`timescale 1ns/1ps
`default_nettype none
`include "rpg_map.svh"
// Operation
// - output 3 masks sleep inputs 6, 3
// - output 2 masks sleep inputs 6, 3
// - output 4 masks sleep inputs 6, 3
// - output 1 masks sleep inputs 6, 3
// - aux discharge code: none/100/200/500 ohm
// - shutdown config 0: rail off for timed duration
// - shutdown config 1: ignore shutdown, follow enable
// - stored config selects regulator or switch B2
// - four-bit code sets aux regulator voltage
// - enable bit turns selected aux rail on
// - status shows eight rails in regulation
// - status resets zero, writes ignored
module rpg_rail_ctrl #(
   parameter int unsigned CYC_1MS   = `RPG_US_TO_CYC(`RPG_SDWN_1MS_US),
   parameter int unsigned CYC_5MS   = `RPG_US_TO_CYC(`RPG_SDWN_5MS_US),
   parameter int unsigned CYC_10MS  = `RPG_US_TO_CYC(`RPG_SDWN_10MS_US),
   parameter int unsigned CYC_100MS = `RPG_US_TO_CYC(`RPG_SDWN_100MS_US)
) (
   input  wire logic             clk_sys_i,      // system clock 100 MHz
   input  wire logic             rstn_i,         // async reset, low active
   input  wire logic             ce_i,           // clock enable, freezes all
   input  wire rpg_pkg::rpg_req_t req_i,         // register access request
   output var  logic [7:0]       rdata_o,        // read data, next cycle
   input  wire logic [7:0]       otp_mask_i,     // stored pin mask image
   input  wire logic [7:0]       otp_term_i,     // stored discharge image
   input  wire logic [7:0]       otp_aux_i,      // stored aux control image
   input  wire logic             otp_use_sw_b2_i,// stored: act on switch B2
   input  wire logic [1:0]       otp_sdwn_dur_i, // stored: off-time select
   input  wire logic             sleep3_i,       // sleep control input 3
   input  wire logic             sleep6_i,       // sleep control input 6
   input  wire logic [3:0]       tree_good_i,    // other tree members good
   input  wire logic [7:0]       rail_good_i,    // eight rail good levels
   input  wire logic             emerg_sdwn_i,   // emergency shutdown pulse
   output var  logic [3:0]       out_good_o,     // outputs 1..4 good
   output var  logic             term_disch_o,   // termination discharge on
   output var  rpg_pkg::rpg_aux_t aux_o,         // aux regulator controls
   output var  logic             sw_b2_en_o      // load switch B2 enable
);
   import rpg_pkg::*;

   typedef struct packed {
      logic       loaded;
      logic [7:0] mask;
      logic [7:0] term;
      logic [7:0] aux;
      logic [7:0] good;
      logic [7:0] rdata;
      logic [3:0] out_good;
      logic       term_disch;
      rpg_aux_t   aux_out;
      logic       sw_b2_en;
   } rpg_state_t;
   rpg_state_t s, next_s;
   logic       sdwn_off;
   logic       rail_on;

   // good when the input is good or masked out of the tree
   function automatic logic tree_ok(input logic mem_good,
                                    input logic s6, input logic m6,
                                    input logic s3, input logic m3);
      tree_ok = mem_good & (s6 | m6) & (s3 | m3);
   endfunction : tree_ok

   // shutdown off-time, bypassed entirely when configured to ignore
   rpg_sdwn_timer #(
      .CYC_1MS   (CYC_1MS),
      .CYC_5MS   (CYC_5MS),
      .CYC_10MS  (CYC_10MS),
      .CYC_100MS (CYC_100MS)
   ) u_sdwn (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .ce_i      (ce_i),
      .start_i   (emerg_sdwn_i & ~s.aux[`RPG_AUX_SDWN_BIT]),
      .dur_sel_i (otp_sdwn_dur_i),
      .off_o     (sdwn_off)
   );

   // ignore-config follows only the enable bit
   assign rail_on = s.aux[`RPG_AUX_EN_BIT] &
                    (s.aux[`RPG_AUX_SDWN_BIT] | ~sdwn_off);

   // register writes, status capture and output drive
   always_comb begin
      next_s = s;
      if (!s.loaded) begin
         // no fixed reset value: images come from stored config
         next_s.mask   = otp_mask_i;
         next_s.term   = otp_term_i;
         next_s.aux    = otp_aux_i;
         next_s.loaded = 1'b1;
      end else if (req_i.wr) begin
         // reserved bits stored as written; host keeps them matched
         if (req_i.addr == `RPG_OFS_PIN_MASK) begin
            next_s.mask = req_i.wdata;
         end else if (req_i.addr == `RPG_OFS_TERM_DISCH) begin
            next_s.term = req_i.wdata;
         end else if (req_i.addr == `RPG_OFS_AUX_CTRL) begin
            next_s.aux = req_i.wdata;
         end
         // status offset is read-only: write dropped
      end
      next_s.good = rail_good_i;
      next_s.rdata = 8'h00;
      if (req_i.rd) begin
         if (req_i.addr == `RPG_OFS_PIN_MASK) begin
            next_s.rdata = s.mask;
         end else if (req_i.addr == `RPG_OFS_TERM_DISCH) begin
            next_s.rdata = s.term;
         end else if (req_i.addr == `RPG_OFS_AUX_CTRL) begin
            next_s.rdata = s.aux;
         end else if (req_i.addr == `RPG_OFS_GOOD_LOW) begin
            next_s.rdata = s.good;
         end
      end
      // mask bit order: out3 7:6, out2 5:4, out4 3:2, out1 1:0
      next_s.out_good[2] = tree_ok(tree_good_i[2], sleep6_i, s.mask[7],
                                   sleep3_i, s.mask[6]);
      next_s.out_good[1] = tree_ok(tree_good_i[1], sleep6_i, s.mask[5],
                                   sleep3_i, s.mask[4]);
      next_s.out_good[3] = tree_ok(tree_good_i[3], sleep6_i, s.mask[3],
                                   sleep3_i, s.mask[2]);
      next_s.out_good[0] = tree_ok(tree_good_i[0], sleep6_i, s.mask[1],
                                   sleep3_i, s.mask[0]);
      next_s.term_disch = s.term[`RPG_TERM_DISCH_BIT];
      next_s.aux_out.disch_sel =
         s.aux[`RPG_AUX_DISCH_HI:`RPG_AUX_DISCH_LO];
      next_s.aux_out.sdwn_ignore = s.aux[`RPG_AUX_SDWN_BIT];
      next_s.aux_out.vcode = s.aux[`RPG_AUX_VID_HI:`RPG_AUX_VID_LO];
      // the shared controls steer one rail only, chosen by config
      next_s.aux_out.enable = rail_on & ~otp_use_sw_b2_i;
      next_s.sw_b2_en       = rail_on & otp_use_sw_b2_i;
   end

   // single state register, frozen while clock enable is low
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= '0;
         s.good <= `RPG_GOOD_RESET;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign rdata_o      = s.rdata;
   assign out_good_o   = s.out_good;
   assign term_disch_o = s.term_disch;
   assign aux_o        = s.aux_out;
   assign sw_b2_en_o   = s.sw_b2_en;

   // output 3 tree follows its sleep 6 mask bit
   property p_out3_mask;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && !sleep6_i && !s.mask[7])
         |=> !out_good_o[2];
   endproperty
   a_out3_mask: assert property (p_out3_mask)
      else $error("out3 good with sleep6 low unmasked");

   property p_out2_mask;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && !sleep3_i && !s.mask[4])
         |=> !out_good_o[1];
   endproperty
   a_out2_mask: assert property (p_out2_mask)
      else $error("out2 good with sleep3 low unmasked");

   property p_out4_mask;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && tree_good_i[3] && s.mask[3:2] == 2'h3)
         |=> out_good_o[3];
   endproperty
   a_out4_mask: assert property (p_out4_mask)
      else $error("out4 not good with both sleep inputs masked");

   property p_out1_mask;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && !sleep6_i && !s.mask[1])
         |=> !out_good_o[0];
   endproperty
   a_out1_mask: assert property (p_out1_mask)
      else $error("out1 good with sleep6 low unmasked");

   property p_status_ro;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && req_i.wr && req_i.addr == `RPG_OFS_GOOD_LOW)
         |=> (s.good == $past(rail_good_i));
   endproperty
   a_status_ro: assert property (p_status_ro)
      else $error("status changed by a write");

   property p_ignore_sdwn;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.aux[`RPG_AUX_SDWN_BIT] && s.aux[`RPG_AUX_EN_BIT]
         && $past(ce_i))
         |=> (aux_o.enable | sw_b2_en_o);
   endproperty
   a_ignore_sdwn: assert property (p_ignore_sdwn)
      else $error("ignore-config rail not on");

   property p_one_rail;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      !(aux_o.enable && sw_b2_en_o);
   endproperty
   a_one_rail: assert property (p_one_rail)
      else $error("both aux rail targets enabled");

   property p_vcode;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && req_i.wr && s.loaded && req_i.addr == `RPG_OFS_AUX_CTRL)
         ##1 ce_i |=> aux_o.vcode == $past(req_i.wdata[4:1], 2);
   endproperty
   a_vcode: assert property (p_vcode)
      else $error("voltage code did not follow write");

   // the second sleep input of outputs 3, 2 and 1, and sleep 6 of output 4, checked on its own
   property p_out3_sleep3;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && !sleep3_i && !s.mask[6])
         |=> !out_good_o[2];
   endproperty
   a_out3_sleep3: assert property (p_out3_sleep3)
      else $error("out3 good with sleep3 low unmasked");

   property p_out2_sleep6;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && !sleep6_i && !s.mask[5])
         |=> !out_good_o[1];
   endproperty
   a_out2_sleep6: assert property (p_out2_sleep6)
      else $error("out2 good with sleep6 low unmasked");

   property p_out4_sleep6;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && !sleep6_i && !s.mask[3])
         |=> !out_good_o[3];
   endproperty
   a_out4_sleep6: assert property (p_out4_sleep6)
      else $error("out4 good with sleep6 low unmasked");

   property p_out1_sleep3;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && !sleep3_i && !s.mask[0])
         |=> !out_good_o[0];
   endproperty
   a_out1_sleep3: assert property (p_out1_sleep3)
      else $error("out1 good with sleep3 low unmasked");

   // a failing tree member pulls its output low whatever the masks
   property p_member_bad;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && tree_good_i != 4'hf)
         |=> (out_good_o & ~$past(tree_good_i)) == 4'h0;
   endproperty
   a_member_bad: assert property (p_member_bad)
      else $error("output good with a failing tree member");

   // with every sleep input masked only the members count
   property p_all_masked;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && s.loaded && s.mask == 8'hff)
         |=> out_good_o == $past(tree_good_i);
   endproperty
   a_all_masked: assert property (p_all_masked)
      else $error("masked sleep input still affects an output");

   property p_term_disch;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i |=> term_disch_o == $past(s.term[`RPG_TERM_DISCH_BIT]);
   endproperty
   a_term_disch: assert property (p_term_disch)
      else $error("termination discharge does not follow its bit");

   property p_aux_disch;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i |=> aux_o.disch_sel
         == $past(s.aux[`RPG_AUX_DISCH_HI:`RPG_AUX_DISCH_LO]);
   endproperty
   a_aux_disch: assert property (p_aux_disch)
      else $error("aux discharge code does not follow its field");

   // a running off time holds the selected rail low
   property p_sdwn_off;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && !s.aux[`RPG_AUX_SDWN_BIT] && sdwn_off)
         |=> !aux_o.enable && !sw_b2_en_o;
   endproperty
   a_sdwn_off: assert property (p_sdwn_off)
      else $error("aux rail on during shutdown off time");

   property p_rail_target;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i |=> ($past(otp_use_sw_b2_i) ? !aux_o.enable : !sw_b2_en_o);
   endproperty
   a_rail_target: assert property (p_rail_target)
      else $error("enable steered to the unselected rail");

   property p_rail_disable;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && !s.aux[`RPG_AUX_EN_BIT])
         |=> !aux_o.enable && !sw_b2_en_o;
   endproperty
   a_rail_disable: assert property (p_rail_disable)
      else $error("aux rail on with enable bit clear");

   property p_good_read;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && req_i.rd && req_i.addr == `RPG_OFS_GOOD_LOW)
         |=> rdata_o == $past(s.good);
   endproperty
   a_good_read: assert property (p_good_read)
      else $error("status read does not return captured status");

   // first enabled edge after reset copies every stored image
   property p_load;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ce_i && !s.loaded)
         |=> {s.mask, s.term, s.aux}
            == $past({otp_mask_i, otp_term_i, otp_aux_i});
   endproperty
   a_load: assert property (p_load)
      else $error("stored images not loaded after reset");
endmodule : rpg_rail_ctrl
`default_nettype wire

// ==== hdl/rpg_sdwn_timer.sv ====
// emergency shutdown off-time timer for the auxiliary rail
`timescale 1ns/1ps
`default_nettype none
`include "rpg_map.svh"
module rpg_sdwn_timer #(
   parameter int unsigned CYC_1MS   = `RPG_US_TO_CYC(`RPG_SDWN_1MS_US),
   parameter int unsigned CYC_5MS   = `RPG_US_TO_CYC(`RPG_SDWN_5MS_US),
   parameter int unsigned CYC_10MS  = `RPG_US_TO_CYC(`RPG_SDWN_10MS_US),
   parameter int unsigned CYC_100MS = `RPG_US_TO_CYC(`RPG_SDWN_100MS_US)
) (
   input  wire logic       clk_sys_i,   // system clock
   input  wire logic       rstn_i,      // async reset, low active
   input  wire logic       ce_i,        // clock enable
   input  wire logic       start_i,     // shutdown event pulse
   input  wire logic [1:0] dur_sel_i,   // factory duration select
   output var  logic       off_o        // rail forced off
);
   import rpg_pkg::*;
   typedef struct packed {
      rpg_sdwn_st_t st;
      logic [23:0]  cnt;
      logic         off;
   } rpg_tmr_state_t;
   rpg_tmr_state_t s, next_s;

   // duration table, cycles at the system clock
   function automatic logic [23:0] dur_cyc(input logic [1:0] sel);
      case (sel)
         2'h0:    dur_cyc = 24'(CYC_1MS);
         2'h1:    dur_cyc = 24'(CYC_5MS);
         2'h2:    dur_cyc = 24'(CYC_10MS);
         default: dur_cyc = 24'(CYC_100MS);
      endcase
   endfunction : dur_cyc

   // a new event while running restarts the full off time
   always_comb begin
      next_s = s;
      case (s.st)
         RPG_ST_IDLE: begin
            if (start_i) begin
               next_s.st  = RPG_ST_RUN;
               next_s.cnt = dur_cyc(dur_sel_i) - 24'h000001;
               next_s.off = 1'b1;
            end
         end
         RPG_ST_RUN: begin
            if (start_i) begin
               next_s.cnt = dur_cyc(dur_sel_i) - 24'h000001;
            end else if (s.cnt == 24'h000000) begin
               next_s.st  = RPG_ST_HOLD;
               next_s.off = 1'b0;
            end else begin
               next_s.cnt = s.cnt - 24'h000001;
            end
         end
         RPG_ST_HOLD: begin
            // an event in the release cycle must not be lost
            next_s.st = RPG_ST_IDLE;
            if (start_i) begin
               next_s.st  = RPG_ST_RUN;
               next_s.cnt = dur_cyc(dur_sel_i) - 24'h000001;
               next_s.off = 1'b1;
            end
         end
         default: begin
            next_s.st = RPG_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= '{st: RPG_ST_IDLE, cnt: 24'h000000, off: 1'b0};
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign off_o = s.off;
endmodule : rpg_sdwn_timer
`default_nettype wire

// ==== test/rpg_host_model.sv ====
// host side model: issues single byte register requests to the device
`timescale 1ns/1ps
`default_nettype none
`include "rpg_map.svh"
module rpg_host_model (
   input  wire logic             clk_sys_i,  // system clock
   input  wire logic [7:0]       otp_term_i, // stored discharge image
   input  wire logic [7:0]       rdata_i,    // read data from device
   output var  rpg_pkg::rpg_req_t req_o      // request to device
);
   import rpg_pkg::*;

   // idle from time zero so nothing is taken during reset or load
   initial begin
      req_o = '0;
   end

   // one request per call, launched and released on falling edges;
   // released address and data show the inverse, wr and rd drop low, so late sampling is caught
   task automatic xfer(input logic wr, input logic [7:0] addr,
                       input logic [7:0] wdata, output logic [7:0] rdata);
      @(negedge clk_sys_i);
      req_o = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
      @(negedge clk_sys_i);
      rdata = rdata_i;
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
   endtask : xfer

   // reserved bits keep the stored image, only the discharge bit moves
   task automatic wr_term(input logic disch);
      logic [7:0] unused;
      xfer(1'b1, `RPG_OFS_TERM_DISCH,
           {otp_term_i[7:5], disch, otp_term_i[3:0]}, unused);
   endtask : wr_term
endmodule : rpg_host_model
`default_nettype wire

// ==== test/tb.sv ====
// self-checking testbench for the rail mask and aux rail register bank
`timescale 1ns/1ps
`default_nettype none
`include "rpg_map.svh"
module tb;
   import rpg_pkg::*;
   logic       clk_sys_i, rstn_i, ce_i, sleep3_i, sleep6_i, emerg_sdwn_i;
   logic       otp_use_sw_b2_i, term_disch_o, sw_b2_en_o;
   logic [7:0] otp_mask_i, otp_term_i, otp_aux_i, rail_good_i, rdata_o, rd;
   logic [3:0] tree_good_i, out_good_o;
   logic [1:0] otp_sdwn_dur_i;
   rpg_req_t   req_i;
   rpg_aux_t   aux_o;
   int         failures, check_count, n;

   rpg_host_model i_host (.clk_sys_i(clk_sys_i), .otp_term_i(otp_term_i),
      .rdata_i(rdata_o), .req_o(req_i));

   // short off-time counts keep the shutdown runs brief
   rpg_rail_ctrl #(.CYC_1MS(4), .CYC_5MS(8), .CYC_10MS(12), .CYC_100MS(16))
   i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .req_i(req_i), .rdata_o(rdata_o), .otp_mask_i(otp_mask_i),
      .otp_term_i(otp_term_i), .otp_aux_i(otp_aux_i),
      .otp_use_sw_b2_i(otp_use_sw_b2_i), .otp_sdwn_dur_i(otp_sdwn_dur_i),
      .sleep3_i(sleep3_i), .sleep6_i(sleep6_i), .tree_good_i(tree_good_i),
      .rail_good_i(rail_good_i), .emerg_sdwn_i(emerg_sdwn_i),
      .out_good_o(out_good_o), .term_disch_o(term_disch_o),
      .aux_o(aux_o), .sw_b2_en_o(sw_b2_en_o));

   // 100 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk

   // write data stays in the caller's variable: read-back goes elsewhere
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] unused;
      i_host.xfer(1'b1, a, d, unused);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_host.xfer(1'b0, a, 8'h00, rd);
      chk(exp, rd);
   endtask : rd_chk

   // register to output takes two edges, so allow both to land
   task automatic settle;
      repeat (2) @(negedge clk_sys_i);
   endtask : settle

   task automatic do_reset;
      @(negedge clk_sys_i);
      rstn_i = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
   endtask : do_reset

   task automatic test_done;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   // enable goes to the regulator or to switch B2, never both
   function automatic logic [7:0] aux_exp(input logic [7:0] v);
      return {v[7:1], v[0] & ~otp_use_sw_b2_i};
   endfunction : aux_exp

   function automatic logic rail_on;
      return otp_use_sw_b2_i ? sw_b2_en_o : aux_o.enable;
   endfunction : rail_on

   function automatic logic [3:0] good_exp(input logic [7:0] m);
      logic [7:0] k;
      k = m | {4{sleep6_i, sleep3_i}};
      return tree_good_i & {k[3] & k[2], k[7] & k[6], k[5] & k[4],
                            k[1] & k[0]};
   endfunction : good_exp

   // main sequence: one reset per off-time select, switch B2 on odd ones, then the rest
   initial begin
      {rstn_i, ce_i, sleep3_i, sleep6_i, emerg_sdwn_i} = 5'b01110;
      {otp_mask_i, otp_term_i, otp_aux_i} = {8'h5a, 8'h55, 8'h9b};
      {rail_good_i, tree_good_i, failures, check_count} = '0;
      for (int r = 0; r < 4; r++) begin
         otp_sdwn_dur_i = r[1:0];
         otp_use_sw_b2_i = r[0];
         do_reset;
         rd_chk(`RPG_OFS_GOOD_LOW, `RPG_GOOD_RESET);
         rd_chk(`RPG_OFS_PIN_MASK, otp_mask_i);
         rd_chk(`RPG_OFS_TERM_DISCH, otp_term_i);
         rd_chk(`RPG_OFS_AUX_CTRL, otp_aux_i);
         chk(aux_exp(otp_aux_i), aux_o);
         for (int k = 0; k < 8; k++) begin
            rd = {k[1:0], 1'b1, k[2] ? 4'ha : 4'h5, k[0] ^ k[2]};
            wr(`RPG_OFS_AUX_CTRL, rd);
            settle;
            chk(aux_exp(rd), aux_o);
            chk({7'h0, rd[0] & r[0]}, {7'h0, sw_b2_en_o});
         end
         for (int c = 0; c < 2; c++) begin
            wr(`RPG_OFS_AUX_CTRL, {2'b00, c[0], 4'h1, 1'b1});
            settle;
            @(negedge clk_sys_i) emerg_sdwn_i = 1'b1;
            @(negedge clk_sys_i) emerg_sdwn_i = 1'b0;
            n = 0;
            repeat (40) @(negedge clk_sys_i) n += int'(!rail_on());
            chk((c == 1) ? 8'h00 : 8'(4 + 4 * r), 8'(n));
            chk(8'h01, {7'h0, rail_on()});
         end
      end
      // every mask pattern against every sleep input combination
      for (int m = 0; m < 256; m++) begin
         wr(`RPG_OFS_PIN_MASK, m[7:0]);
         for (int s = 0; s < 4; s++) begin
            {sleep6_i, sleep3_i} = s[1:0];
            tree_good_i = (s == 3) ? m[3:0] : 4'hf;
            settle;
            chk({4'h0, good_exp(m[7:0])}, {4'h0, out_good_o});
         end
      end
      rd_chk(`RPG_OFS_PIN_MASK, 8'hff);
      for (int d = 0; d < 2; d++) begin
         i_host.wr_term(d[0]);
         settle;
         chk({7'h0, d[0]}, {7'h0, term_disch_o});
         rd_chk(`RPG_OFS_TERM_DISCH, {8'h55 & 8'hef} | {3'h0, d[0], 4'h0});
      end
      rail_good_i = 8'ha5;
      settle;
      rd_chk(`RPG_OFS_GOOD_LOW, 8'ha5);
      wr(`RPG_OFS_GOOD_LOW, 8'h5a);
      rd_chk(`RPG_OFS_GOOD_LOW, 8'ha5);
      rd_chk(8'haf, 8'h00);
      rail_good_i = 8'h3c;
      settle;
      rd_chk(`RPG_OFS_GOOD_LOW, 8'h3c);
      // a write with the clock enable low must not land
      ce_i = 1'b0;
      wr(`RPG_OFS_AUX_CTRL, 8'h00);
      ce_i = 1'b1;
      rd_chk(`RPG_OFS_AUX_CTRL, 8'h23);
      test_done;
   end
endmodule : tb
`default_nettype wire
